// File: design/cdn_core_compactor.sv
// Purpose: compacted core numbers, enabled count and boot core
// Assumes: enabled already limited to present cores
// Notes:   base shifts the numbers for the second internal node
`timescale 1ns/1ns
module cdn_core_compactor
	import cdn_pkg::*;
#(
	parameter int N = CDN_MAX_CORES
) (
	input  wire logic [N-1:0]           enabled,
	input  wire logic [CDN_NUM_W-1:0]   base,
	output logic      [N*CDN_NUM_W-1:0] number,
	output logic      [CDN_NUM_W-1:0]   count,
	output logic      [N-1:0]           boot_onehot
);
	function automatic logic [CDN_NUM_W-1:0] ones_below(input logic [N-1:0] v, input int k);
		logic [CDN_NUM_W-1:0] c;
		c = '0;
		for (int j = 0; j < N; j++) begin
			if (j < k && v[j]) begin
				c = c + 4'h1;
			end
		end
		return c;
	endfunction

	assign count = ones_below(enabled, N);

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_core
			logic [CDN_NUM_W-1:0] below;
			assign below = ones_below(enabled, i);
			assign number[i*CDN_NUM_W +: CDN_NUM_W] = enabled[i] ? below + base : '0;
			assign boot_onehot[i] = enabled[i] && below == '0 && base == '0;
		end
	endgenerate
endmodule

// File: design/cdn_core_ctrl.sv
// Purpose: core disable, compacted numbering and id views for one node
// Assumes: aresetn is the cold reset; warm_reset is a synchronous level
// Notes:   straps caught on the first edge after cold reset release
// How it works
// - one to six cores per node; present count is a read-only field.
// - six-bit disable mask; only bits below the capability count.
// - core count reported for identification excludes disabled cores.
// - a removed core stays removed until cold reset.
// - enabled cores get compacted numbers from zero upward.
// - the core numbered zero is the boot core.
// - numbers shown through id views, formatted by format select bit.
// - numbering decides the per-core enable bits one to five.
// - boot processor splits numbers by node identifier bit 0.
// - application processors split numbers by internal node number.
// - dual-node id format carries node bits 2:1; full id readable.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
module cdn_core_ctrl
	import cdn_pkg::*;
#(
	parameter int N = CDN_MAX_CORES
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   warm_reset,
	input  wire logic [2:0]             strap_core_count,
	input  wire logic                   strap_dual_node,
	input  wire logic                   strap_internal_node,
	input  wire logic [CDN_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [CDN_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [N-1:0]                core_enable,
	output logic [N-1:1]                core_enable_flags,
	output logic [N*CDN_NUM_W-1:0]      compacted_core_number,
	output logic [N*CDN_ID_W-1:0]       interrupt_controller_id,
	output logic [N-1:0]                boot_core,
	output logic [CDN_NUM_W-1:0]        id_core_count
);
	logic                       straps_taken_q, straps_taken_d;
	logic [2:0]                 core_capability_q, core_capability_d;
	logic                       dual_q, dual_d;
	logic                       int_node_q, int_node_d;
	logic [N-1:0]               pending_q, pending_d;
	logic [N-1:0]               applied_q, applied_d;
	logic [2:0]                 node_id_q, node_id_d;
	logic                       fmt_q, fmt_d;
	logic                       bsp_q, bsp_d;
	logic [7:0]                 sys_count_q, sys_count_d;
	logic                       aw_full_q, aw_full_d;
	logic [CDN_ADDR_W-1:0]      awaddr_q, awaddr_d;
	logic                       w_full_q, w_full_d;
	logic [31:0]                wdata_q, wdata_d;
	logic [3:0]                 wstrb_q, wstrb_d;
	logic                       awready_q, awready_d;
	logic                       wready_q, wready_d;
	logic                       bvalid_q, bvalid_d;
	logic [1:0]                 bresp_q, bresp_d;
	logic                       arready_q, arready_d;
	logic                       rvalid_q, rvalid_d;
	logic [31:0]                rdata_q, rdata_d;
	logic [1:0]                 rresp_q, rresp_d;
	logic [N-1:0]               en_q;
	logic [N-1:1]               flags_q;
	logic [N*CDN_NUM_W-1:0]     num_q;
	logic [N*CDN_ID_W-1:0]      id_q;
	logic [N-1:0]               boot_q;
	logic [CDN_NUM_W-1:0]       nc_q;
	logic [N-1:0]               cap_mask;
	logic [N-1:0]               enabled_now;
	logic [CDN_NUM_W-1:0]       base;
	logic [CDN_NUM_W-1:0]       node_count;
	logic [CDN_NUM_W-1:0]       nc_d;
	logic [N-1:1]               flags_d;
	logic [N*CDN_NUM_W-1:0]     num_w;
	logic [N*CDN_ID_W-1:0]      id_w;
	logic [N-1:0]               boot_w;

	function automatic logic [N-1:0] mask_of(input logic [2:0] cnt);
		logic [N-1:0] m;
		m = '0;
		for (int j = 0; j < N; j++) begin
			if (j < int'(cnt)) begin
				m[j] = 1'b1;
			end
		end
		return m;
	endfunction

	assign cap_mask    = mask_of(core_capability_q);
	assign enabled_now = cap_mask & ~applied_q;

	always_comb begin
		base = '0;
		if (dual_q) begin
			// boot processor splits on node id
			if (bsp_q) begin
				base = node_id_q[0] ? node_count : '0;
			end else begin
				base = int_node_q ? node_count : '0;
			end
		end
	end

	cdn_core_compactor #(
		.N           (N)
	) u_compactor (
		.enabled     (enabled_now),
		.base        (base),
		.number      (num_w),
		.count       (node_count),
		.boot_onehot (boot_w)
	);

	cdn_id_format #(
		.N                (N)
	) u_id_format (
		.number           (num_w),
		.node_identifier  (node_id_q),
		.dual_node        (dual_q),
		.id_format_select (fmt_q),
		.id               (id_w)
	);

	always_comb begin
		nc_d = (dual_q ? {node_count[CDN_NUM_W-2:0], 1'b0} : node_count) - 4'h1;
		// enable bit k means number k exists
		for (int k = 1; k < N; k++) begin
			flags_d[k] = (base + node_count) > CDN_NUM_W'(k) ||
				(dual_q && {node_count[CDN_NUM_W-2:0], 1'b0} > CDN_NUM_W'(k));
		end
	end

	always_comb begin
		straps_taken_d    = 1'b1;
		core_capability_d = core_capability_q;
		dual_d            = dual_q;
		int_node_d        = int_node_q;
		pending_d         = pending_q;
		applied_d         = applied_q;
		node_id_d         = node_id_q;
		fmt_d             = fmt_q;
		bsp_d             = bsp_q;
		sys_count_d       = sys_count_q;
		aw_full_d         = aw_full_q;
		awaddr_d          = awaddr_q;
		w_full_d          = w_full_q;
		wdata_d           = wdata_q;
		wstrb_d           = wstrb_q;
		bvalid_d          = bvalid_q;
		bresp_d           = bresp_q;
		rvalid_d          = rvalid_q;
		rdata_d           = rdata_q;
		rresp_d           = rresp_q;
		// capability caught once, clamped to 1..6
		if (!straps_taken_q) begin
			core_capability_d = (strap_core_count == 3'h0) ? 3'h1 :
				(strap_core_count > 3'h6) ? 3'h6 : strap_core_count;
			dual_d            = strap_dual_node;
			int_node_d        = strap_internal_node;
		end
		// mask takes effect at warm reset
		if (warm_reset) begin
			applied_d = applied_q | (pending_q & cap_mask);
		end
		if (s_axi_awvalid && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_full_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_full_q && w_full_q && !bvalid_q) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			case ({awaddr_q[CDN_ADDR_W-1:2], 2'b00})
				ADDR_CAP, ADDR_APPLIED, ADDR_CORE_EN, ADDR_NUMBERS: begin
				end
				ADDR_DISABLE: begin
					if (wstrb_q[0]) begin
						pending_d = wdata_q[N-1:0];
					end
				end
				ADDR_NODE: begin
					if (wstrb_q[0]) begin
						node_id_d = wdata_q[NODE_ID_LSB +: 3];
					end
					if (wstrb_q[1]) begin
						fmt_d = wdata_q[NODE_FMT_BIT];
						bsp_d = wdata_q[NODE_BSP_BIT];
					end
				end
				ADDR_COUNT: begin
					if (wstrb_q[0]) begin
						sys_count_d = wdata_q[7:0];
					end
				end
				default: begin
					bresp_d = RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = '0;
			case ({s_axi_araddr[CDN_ADDR_W-1:2], 2'b00})
				ADDR_CAP: begin
					rdata_d[CAP_COUNT_LSB +: 3] = core_capability_q;
					rdata_d[CAP_DUAL_BIT]       = dual_q;
					rdata_d[CAP_INODE_BIT]      = int_node_q;
				end
				ADDR_DISABLE: rdata_d[N-1:0] = pending_q;
				ADDR_APPLIED: begin
					rdata_d[N-1:0]                       = applied_q;
					rdata_d[APPL_CNT_LSB +: CDN_NUM_W]   = node_count;
				end
				ADDR_NODE: begin
					rdata_d[NODE_ID_LSB +: 3] = node_id_q;
					rdata_d[NODE_FMT_BIT]     = fmt_q;
					rdata_d[NODE_BSP_BIT]     = bsp_q;
				end
				ADDR_COUNT:   rdata_d[7:0]   = sys_count_q;
				ADDR_CORE_EN: rdata_d[N-1:1] = flags_q;
				ADDR_NUMBERS: rdata_d[N*CDN_NUM_W-1:0] = num_q;
				default: rresp_d = RESP_SLVERR;
			endcase
		end
		awready_d = !aw_full_d && !bvalid_d;
		wready_d  = !w_full_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			straps_taken_q    <= 1'b0;
			core_capability_q <= 3'h1;
			dual_q            <= 1'b0;
			int_node_q        <= 1'b0;
			pending_q         <= DISABLE_RST;
			applied_q         <= DISABLE_RST;
			node_id_q         <= NODE_ID_RST;
			fmt_q             <= NODE_FMT_RST;
			bsp_q             <= NODE_BSP_RST;
			sys_count_q       <= COUNT_RST;
			aw_full_q         <= 1'b0;
			awaddr_q          <= '0;
			w_full_q          <= 1'b0;
			wdata_q           <= '0;
			wstrb_q           <= '0;
			awready_q         <= 1'b0;
			wready_q          <= 1'b0;
			bvalid_q          <= 1'b0;
			bresp_q           <= RESP_OKAY;
			arready_q         <= 1'b0;
			rvalid_q          <= 1'b0;
			rdata_q           <= '0;
			rresp_q           <= RESP_OKAY;
			en_q              <= '0;
			flags_q           <= '0;
			num_q             <= '0;
			id_q              <= '0;
			boot_q            <= '0;
			nc_q              <= '0;
		end else begin
			straps_taken_q    <= straps_taken_d;
			core_capability_q <= core_capability_d;
			dual_q            <= dual_d;
			int_node_q        <= int_node_d;
			pending_q         <= pending_d;
			applied_q         <= applied_d;
			node_id_q         <= node_id_d;
			fmt_q             <= fmt_d;
			bsp_q             <= bsp_d;
			sys_count_q       <= sys_count_d;
			aw_full_q         <= aw_full_d;
			awaddr_q          <= awaddr_d;
			w_full_q          <= w_full_d;
			wdata_q           <= wdata_d;
			wstrb_q           <= wstrb_d;
			awready_q         <= awready_d;
			wready_q          <= wready_d;
			bvalid_q          <= bvalid_d;
			bresp_q           <= bresp_d;
			arready_q         <= arready_d;
			rvalid_q          <= rvalid_d;
			rdata_q           <= rdata_d;
			rresp_q           <= rresp_d;
			en_q              <= enabled_now;
			flags_q           <= flags_d;
			num_q             <= num_w;
			id_q              <= id_w;
			boot_q            <= boot_w;
			nc_q              <= nc_d;
		end
	end

	assign s_axi_awready           = awready_q;
	assign s_axi_wready            = wready_q;
	assign s_axi_bvalid            = bvalid_q;
	assign s_axi_bresp             = bresp_q;
	assign s_axi_arready           = arready_q;
	assign s_axi_rvalid            = rvalid_q;
	assign s_axi_rdata             = rdata_q;
	assign s_axi_rresp             = rresp_q;
	assign core_enable             = en_q;
	assign core_enable_flags       = flags_q;
	assign compacted_core_number   = num_q;
	assign interrupt_controller_id = id_q;
	assign boot_core               = boot_q;
	assign id_core_count           = nc_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_warm;
		warm_reset;
	endsequence
	sequence s_mask_taken;
		##1 applied_q == $past(applied_q | (pending_q & cap_mask));
	endsequence

	property p_cap_range;
		straps_taken_q |-> core_capability_q >= 3'h1 && core_capability_q <= 3'h6;
	endproperty
	a_cap_range: assert property (p_cap_range) else $error("capability out of range");

	property p_warm_apply;
		s_warm |-> s_mask_taken;
	endproperty
	a_warm_apply: assert property (p_warm_apply) else $error("mask not applied");

	property p_count_view;
		straps_taken_q && $past(straps_taken_q, 2) && $stable(applied_q) && $stable(node_id_q)
			|-> int'(id_core_count) == $countones(en_q) * (dual_q ? 2 : 1) - 1;
	endproperty
	a_count_view: assert property (p_count_view) else $error("core count wrong");

	property p_sticky;
		straps_taken_q |=> (($past(applied_q) & ~applied_q) == '0);
	endproperty
	a_sticky: assert property (p_sticky) else $error("removed core returned");

	property p_hold;
		!warm_reset |=> applied_q == $past(applied_q);
	endproperty
	a_hold: assert property (p_hold) else $error("mask changed outside warm reset");

	property p_boot_zero;
		boot_core != '0 |-> (boot_core & core_enable) == boot_core
			&& $countones(boot_core) == 1
			&& boot_core == (core_enable & (~core_enable + N'(1)));
	endproperty
	a_boot_zero: assert property (p_boot_zero) else $error("boot core not number zero");

	property p_first_zero;
		straps_taken_q && !dual_q && enabled_now[0] |=> compacted_core_number[CDN_NUM_W-1:0] == '0;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("first core not zero");

	property p_split;
		dual_q && bsp_q && node_id_q[0] && enabled_now[0]
			|=> compacted_core_number[CDN_NUM_W-1:0] == $past(node_count);
	endproperty
	a_split: assert property (p_split) else $error("node split wrong");

	property p_flag1;
		straps_taken_q && !dual_q |=> core_enable_flags[1] == ($past(node_count) > 4'h1);
	endproperty
	a_flag1: assert property (p_flag1) else $error("core1 enable wrong");
endmodule

// File: design/cdn_id_format.sv
// Purpose: per-core interrupt controller id from core and node numbers
// Assumes: format select and dual-node flag are stable levels
// Notes:   dual-node parts show node bits 2:1 only
`timescale 1ns/1ns
module cdn_id_format
	import cdn_pkg::*;
#(
	parameter int N = CDN_MAX_CORES
) (
	input  wire logic [N*CDN_NUM_W-1:0] number,
	input  wire logic [2:0]             node_identifier,
	input  wire logic                   dual_node,
	input  wire logic                   id_format_select,
	output logic      [N*CDN_ID_W-1:0]  id
);
	logic [2:0] node_field;

	// node bits 2:1 on dual parts
	assign node_field = dual_node ? {1'b0, node_identifier[2:1]} : node_identifier;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_id
			logic [CDN_NUM_W-1:0] num;
			assign num = number[i*CDN_NUM_W +: CDN_NUM_W];
			assign id[i*CDN_ID_W +: CDN_ID_W] = id_format_select ?
				{1'b0, node_field, num} : {num, 1'b0, node_field};
		end
	endgenerate
endmodule

// File: include/cdn_pkg.sv
// Purpose: shared constants for core enable and core numbering
// Assumes: AXI4-Lite register window with byte addresses, 32-bit data
// Notes:   one localparam per offset, field position and reset value
package cdn_pkg;
	localparam int          CDN_MAX_CORES  = 6;
	localparam int          CDN_NUM_W      = 4;
	localparam int          CDN_ID_W       = 8;
	localparam int          CDN_ADDR_W     = 8;
	// register byte offsets
	localparam logic [7:0]  ADDR_CAP       = 8'h00;
	localparam logic [7:0]  ADDR_DISABLE   = 8'h04;
	localparam logic [7:0]  ADDR_APPLIED   = 8'h08;
	localparam logic [7:0]  ADDR_NODE      = 8'h0c;
	localparam logic [7:0]  ADDR_COUNT     = 8'h10;
	localparam logic [7:0]  ADDR_CORE_EN   = 8'h14;
	localparam logic [7:0]  ADDR_NUMBERS   = 8'h18;
	// field positions
	localparam int          CAP_COUNT_LSB  = 0;
	localparam int          CAP_DUAL_BIT   = 4;
	localparam int          CAP_INODE_BIT  = 5;
	localparam int          APPL_CNT_LSB   = 8;
	localparam int          NODE_ID_LSB    = 0;
	localparam int          NODE_FMT_BIT   = 8;
	localparam int          NODE_BSP_BIT   = 9;
	// reset values
	localparam logic [5:0]  DISABLE_RST    = 6'h00;
	localparam logic [2:0]  NODE_ID_RST    = 3'h0;
	localparam logic        NODE_FMT_RST   = 1'b0;
	localparam logic        NODE_BSP_RST   = 1'b1;
	localparam logic [7:0]  COUNT_RST      = 8'h00;
	// bus answers
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// File: testbench/cdn_core_ctrl_test.sv
// Purpose: self-checking bench for core enable and compacted numbering
// Assumes: cdn_core_ctrl with six core slots, registers over AXI4-Lite
// Notes:   warm reset applies the pending mask, cold reset clears it
`timescale 1ns/1ns
module cdn_core_ctrl_test
	import cdn_pkg::*;
;
	logic              aclk = 1'b0;
	logic              aresetn, warm_reset, dual, inode;
	logic [2:0]        cnt;
	logic [7:0]        awaddr, araddr;
	logic [31:0]       wdata, rdata, rd;
	logic              awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [5:0]        core_en, boot;
	logic [5:1]        flags;
	logic [23:0]       nums;
	logic [47:0]       ids;
	logic [3:0]        nc;
	int                mismatches = 0;
	int                checked = 0;

	always #4 aclk = ~aclk;

	cdn_core_ctrl #(.N(CDN_MAX_CORES)) u_cdn_core_ctrl (
		.aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset),
		.strap_core_count(cnt), .strap_dual_node(dual), .strap_internal_node(inode),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .core_enable(core_en), .core_enable_flags(flags),
		.compacted_core_number(nums), .interrupt_controller_id(ids),
		.boot_core(boot), .id_core_count(nc)
	);

	// expected numbering: enabled cores counted upward from base
	function automatic logic [23:0] cnum(input logic [5:0] en, input logic [3:0] base);
		logic [23:0] v;
		logic [3:0]  k;
		v = '0;
		k = base;
		for (int i = 0; i < 6; i++) begin
			if (en[i]) begin
				v[4*i+:4] = k;
				k = k + 4'h1;
			end
		end
		return v;
	endfunction

	task automatic close_out;
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic settle;
		repeat (2) @(posedge aclk);
		#1;
	endtask

	task automatic cold(input logic [2:0] c, input logic d, input logic i);
		@(posedge aclk);
		aresetn <= 1'b0;
		cnt <= c;
		dual <= d;
		inode <= i;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
	endtask

	task automatic warm;
		@(posedge aclk);
		warm_reset <= 1'b1;
		@(posedge aclk);
		warm_reset <= 1'b0;
		settle();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid === 1'b1 && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid === 1'b1 && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er, "write response");
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid === 1'b1 && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk(rresp, er, "read response");
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		axr(a, rd, RESP_OKAY);
		chk(rd & msk, exp, "read data");
	endtask

	task automatic s_regs;
		cold(3'h4, 1'b0, 1'b0);
		rchk(ADDR_CAP, 32'h4, 32'h3f);
		rchk(ADDR_NODE, 32'h200, 32'h3ff);
		rchk(ADDR_DISABLE, 32'h0, 32'h3f);
		axw(ADDR_CAP, 32'h3f, RESP_OKAY);
		rchk(ADDR_CAP, 32'h4, 32'h3f);
		axw(8'h40, 32'h1, RESP_SLVERR);
		axr(8'h40, rd, RESP_SLVERR);
		chk(rd, 32'h0, "unmapped read data");
		chk(core_en, 6'h0f, "enables after cold reset");
		chk(nc, 4'h3, "reported core count");
	endtask

	task automatic s_mask;
		axw(ADDR_DISABLE, 32'h02, RESP_OKAY);
		rchk(ADDR_DISABLE, 32'h02, 32'h3f);
		settle();
		chk(core_en, 6'h0f, "mask applied before warm reset");
		warm();
		chk(core_en, 6'h0d, "enables after warm reset");
		chk(nums, cnum(6'h0d, 4'h0), "compacted numbers");
		chk(boot, 6'h01, "boot core");
		chk(flags, 5'h03, "per-number enables");
		chk(nc, 4'h2, "reported core count");
		rchk(ADDR_APPLIED, 32'h300, 32'hf00);
		axw(ADDR_COUNT, 32'h03, RESP_OKAY);
		rchk(ADDR_COUNT, 32'h03, 32'hff);
		axw(ADDR_DISABLE, 32'h0, RESP_OKAY);
		warm();
		chk(core_en, 6'h0d, "removed core returned on warm reset");
		cold(3'h4, 1'b0, 1'b0);
		chk(core_en, 6'h0f, "cold reset kept a core removed");
	endtask

	task automatic s_six;
		cold(3'h6, 1'b0, 1'b0);
		axw(ADDR_DISABLE, 32'h21, RESP_OKAY);
		warm();
		chk(core_en, 6'h1e, "enables with core 0 removed");
		chk(nums, cnum(6'h1e, 4'h0), "compacted numbers");
		chk(boot, 6'h02, "boot core moved to core 1");
		chk(flags, 5'h07, "per-number enables");
		chk(nc, 4'h3, "reported core count");
		axw(ADDR_NODE, 32'h305, RESP_OKAY);
		settle();
		chk(ids[31:24], 8'h52, "id with format select set");
		axw(ADDR_NODE, 32'h205, RESP_OKAY);
		settle();
		chk(ids[31:24], 8'h25, "id with format select clear");
	endtask

	task automatic s_dual;
		cold(3'h6, 1'b1, 1'b1);
		rchk(ADDR_CAP, 32'h36, 32'h3f);
		chk(nums, cnum(6'h3f, 4'h0), "boot processor on node id 0");
		chk(nc, 4'hb, "package core count");
		axw(ADDR_NODE, 32'h106, RESP_OKAY);
		settle();
		chk(nums, cnum(6'h3f, 4'h6), "second internal node numbers");
		chk(boot, 6'h00, "no boot core on second node");
		chk(flags, 5'h1f, "package per-number enables");
		chk(ids[7:0], 8'h36, "dual-node id carries node bits 2:1");
		axw(ADDR_NODE, 32'h201, RESP_OKAY);
		settle();
		chk(nums, cnum(6'h3f, 4'h6), "boot processor on node id 1");
	endtask

	initial begin
		repeat (4000) @(posedge aclk);
		mismatches++;
		$display("ERROR %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		aresetn = 1'b0;
		warm_reset = 1'b0;
		cnt = 3'h4;
		dual = 1'b0;
		inode = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		s_regs();
		s_mask();
		s_six();
		s_dual();
		close_out();
	end
endmodule
